/* iowdt_defs.vh */
// Constants for the I/O port watchdog timer.
`ifndef IOWDT_DEFS_VH
`define IOWDT_DEFS_VH

// Port address of the interval/control register.
`define IOWDT_PORT_ADDR 16'h0443
// Legal interval codes.
`define IOWDT_MIN_CODE 8'h01
`define IOWDT_MAX_CODE 8'h3E
// Value of the countdown and read data after reset.
`define IOWDT_CNT_RST 8'h00
// One tick of the countdown, in seconds, and the clock rate in Hz.
`define IOWDT_TICK_S 1
`define IOWDT_CLK_HZ 25000000
// Clock cycles in one tick.
`define IOWDT_TICK_CYC (`IOWDT_CLK_HZ * `IOWDT_TICK_S)
// Width of a reset pulse to the processor, in clock cycles.
`define IOWDT_RST_PULSE_CYC 16

`endif

/* iowdt_prescaler.v */
// Divider that makes the one-second tick from the system clock.
`timescale 1ns/1ns
`include "iowdt_defs.vh"
module iowdt_prescaler #(
    parameter DIV = `IOWDT_TICK_CYC,
    parameter W = 25
) (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Control
    input wire clear,
    // Tick out
    output reg tick
);
    // Last count of the divider, cut on purpose to the counter width.
    localparam integer LAST_I = DIV - 1;
    localparam [W-1:0] LAST = LAST_I[W-1:0];

    reg [W-1:0] cnt_reg;

    // A restart clears the divider so the first second is a full second.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (clear) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule

/* iowdt_top.v */
// Watchdog timer reached through one 8-bit I/O port.
`timescale 1ns/1ns
`include "iowdt_defs.vh"
module iowdt_top #(
    parameter TICK_CYC = `IOWDT_TICK_CYC,
    parameter PRE_W = 25,
    parameter RST_PULSE = `IOWDT_RST_PULSE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Host I/O bus, one-cycle strobes
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output reg io_rdata_valid,
    // Static configuration: 1 selects interrupt, 0 selects CPU reset
    input wire expire_irq_mode,
    // Expiry outputs and status
    output reg cpu_reset,
    output reg wdt_irq,
    output reg wdt_running
);
    // One-hot states: idle, counting down, driving the reset pulse.
    localparam ST_IDLE = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_FIRE = 3'h4;

    // Bus decode.
    wire hit;
    wire wr_hit;
    wire rd_hit;
    wire code_ok;
    wire restart;

    // State decode and the events that move the countdown.
    wire tick;
    wire last_sec;
    wire pulse_done;
    wire in_idle;
    wire in_run;
    wire in_fire;
    wire bad_state;
    wire start;
    wire stop;
    wire reload;
    wire expire;
    wire step;

    // Countdown registers and their next values.
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] cnt_reg;
    reg [7:0] cnt_next;
    reg [7:0] pulse_reg;
    reg [7:0] pulse_next;

    // Next values of the registered outputs.
    reg [7:0] io_rdata_next;
    reg io_rdata_valid_next;
    reg cpu_reset_next;
    reg wdt_irq_next;
    reg wdt_running_next;

    assign hit = (io_addr == `IOWDT_PORT_ADDR);
    assign wr_hit = io_wr & hit;
    assign rd_hit = io_rd & hit;
    // Codes outside the table are ignored rather than treated as zero.
    assign code_ok = (io_wdata >= `IOWDT_MIN_CODE) &&
        (io_wdata <= `IOWDT_MAX_CODE);
    // A read in the same cycle disables, so it blocks the write.
    assign restart = wr_hit & code_ok & ~rd_hit;

    iowdt_prescaler #(
        .DIV(TICK_CYC),
        .W(PRE_W)
    ) u_pre (
        .mclk(mclk),
        .reset(reset),
        .clear(restart),
        .tick(tick)
    );

    // The count still shows one during the last second.
    assign last_sec = (cnt_reg == 8'h01);
    assign pulse_done = (pulse_reg == 8'h01);
    assign in_idle = (state_reg == ST_IDLE);
    assign in_run = (state_reg == ST_RUN);
    assign in_fire = (state_reg == ST_FIRE);
    assign bad_state = ~(in_idle | in_run | in_fire);
    assign start = in_idle & restart;
    assign stop = in_run & rd_hit;
    // A refresh wins over a tick that lands in the same cycle.
    assign reload = in_run & restart;
    assign expire = in_run & ~restart & ~rd_hit & tick & last_sec;
    assign step = in_run & ~restart & ~rd_hit & tick & ~last_sec;

    // Read port: the host sees the seconds left before its read acts.
    always @* begin
        io_rdata_next = io_rdata;
        io_rdata_valid_next = rd_hit;
        if (rd_hit) begin
            io_rdata_next = cnt_reg;
        end
    end

    // State sequence.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop) begin
                    state_next = ST_IDLE;
                end else if (expire) begin
                    if (expire_irq_mode) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_FIRE;
                    end
                end
            end
            ST_FIRE: begin
                // The pulse runs its full length whatever the host does.
                if (pulse_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Countdown value.
    always @* begin
        cnt_next = cnt_reg;
        if (start | reload) begin
            cnt_next = io_wdata;
        end else if (expire) begin
            cnt_next = 8'h00;
        end else if (step) begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    // Reset pulse length.
    always @* begin
        pulse_next = pulse_reg;
        if (expire & ~expire_irq_mode) begin
            pulse_next = RST_PULSE[7:0];
        end else if (in_fire) begin
            pulse_next = pulse_reg - 8'h01;
        end
    end

    // Expiry and status outputs.
    always @* begin
        cpu_reset_next = cpu_reset;
        wdt_irq_next = wdt_irq;
        wdt_running_next = wdt_running;
        if (start) begin
            wdt_running_next = 1'h1;
            wdt_irq_next = 1'h0;
        end else if (stop) begin
            wdt_running_next = 1'h0;
        end else if (expire) begin
            wdt_running_next = 1'h0;
            if (expire_irq_mode) begin
                wdt_irq_next = 1'h1;
            end else begin
                cpu_reset_next = 1'h1;
            end
        end
        // An idle read acknowledges a pending interrupt.
        if (in_idle & rd_hit) begin
            wdt_irq_next = 1'h0;
        end
        if (in_fire & pulse_done) begin
            cpu_reset_next = 1'h0;
        end
        // An illegal state code is parked quietly.
        if (bad_state) begin
            wdt_running_next = 1'h0;
            cpu_reset_next = 1'h0;
        end
    end

    // Read port registers.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            io_rdata <= `IOWDT_CNT_RST;
            io_rdata_valid <= 1'h0;
        end else begin
            io_rdata <= io_rdata_next;
            io_rdata_valid <= io_rdata_valid_next;
        end
    end

    // Countdown registers.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `IOWDT_CNT_RST;
            pulse_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    // Expiry outputs leave the block straight from flip-flops.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cpu_reset <= 1'h0;
            wdt_irq <= 1'h0;
            wdt_running <= 1'h0;
        end else begin
            cpu_reset <= cpu_reset_next;
            wdt_irq <= wdt_irq_next;
            wdt_running <= wdt_running_next;
        end
    end
endmodule

/* iowdt_monitor.sv */
// Checker bound to the watchdog top.
`timescale 1ns/1ns
module iowdt_mon #(parameter TICK_CYC = 10) (
    input wire mclk, reset, io_wr, io_rd, io_rdata_valid,
    input wire expire_irq_mode, cpu_reset, wdt_irq, wdt_running,
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata, io_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire h = io_addr == 16'h0443;
    wire rh = io_rd && h;
    wire w = io_wr && h && !io_rd && !cpu_reset;
    wire ok = io_wdata >= 8'h01 && io_wdata <= 8'h3E;
    wire run = wdt_running;
    reg [31:0] n;
    reg [7:0] c;
    // Age of the last accepted write, so expiry time is checked exactly.
    // The tick register and the running flag each add one cycle.
    always @(posedge mclk or posedge reset)
        if (reset) {n, c} <= 40'h0;
        else if (w && ok) {n, c} <= {32'h1, io_wdata};
        else n <= n + 32'h1;
    AST_WR: assert property (w && ok |=> run)
        else $error("write not taken");
    AST_RD: assert property (rh |=> !run)
        else $error("read kept it running");
    AST_VAL: assert property (rh |=> io_rdata_valid)
        else $error("no read data");
    AST_BAD: assert property (w && !ok && !run |=> !run)
        else $error("bad code taken");
    AST_EXP: assert property ($fell(run) && !$past(rh)
        |-> cpu_reset || wdt_irq) else $error("silent expiry");
    AST_TIM: assert property ($fell(run) && !$past(rh)
        |-> n == c * TICK_CYC + 2) else $error("expiry time wrong");
    AST_MOD: assert property ($rose(cpu_reset) |-> !expire_irq_mode)
        else $error("reset in irq mode");
    AST_IRQ: assert property ($rose(wdt_irq) |-> expire_irq_mode)
        else $error("irq in reset mode");
endmodule
bind iowdt_top iowdt_mon #(.TICK_CYC(TICK_CYC)) mon (.*);

/* iowdt_host.sv */
// Host processor model issuing port reads and writes.
`timescale 1ns/1ns
module iowdt_host (
    input wire mclk,
    output logic [15:0] io_addr = 16'hFFFF,
    output logic io_wr = 0,
    output logic io_rd = 0,
    output logic [7:0] io_wdata = 8'hFF,
    input wire [7:0] io_rdata
);
    // A released bus shows inverted values so no stale value can match.
    task wr(input [15:0] a, input [7:0] d);
        @(negedge mclk) {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
        @(negedge mclk) {io_addr, io_wdata, io_wr} = {~a, ~d, 1'b0};
    endtask
    task rd(output [7:0] d);
        @(negedge mclk) {io_addr, io_rd} = {16'h0443, 1'b1};
        @(negedge mclk) {io_addr, io_rd} = {16'hFBBC, 1'b0};
        d = io_rdata;
    endtask
endmodule

/* iowdt_tb_top.sv */
// Self-checking bench for the I/O port watchdog.
`timescale 1ns/1ns
module iowdt_tb_top;
    reg mclk = 0, reset = 1, expire_irq_mode = 0;
    wire [15:0] io_addr;
    wire io_wr, io_rd, io_rdata_valid, cpu_reset, wdt_irq, wdt_running;
    wire [7:0] io_wdata, io_rdata;
    logic [7:0] d;
    logic [23:0] bad [4] = '{24'h044300, 24'h04433F, 24'h0443FF, 24'h044405};
    integer err_total = 0, cmp_count = 0, cyc = 0, n, i;
    // A ten-cycle second keeps the run short.
    iowdt_top #(.TICK_CYC(10), .PRE_W(25), .RST_PULSE(4)) uut (.*);
    iowdt_host host (.*);
    initial forever #20 mclk = ~mclk;
    task chk(input string nm, input [7:0] e, input [7:0] g);
        cmp_count++;
        if (g !== e) err_total++;
        if (g !== e) $display("FAIL %s exp %h got %h", nm, e, g);
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) if (++cyc == 2000) begin
        err_total++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk) reset = 0;
        host.wr(16'h0443, 8'h03);
        host.rd(d);
        chk("rdata", 8'h03, d);
        chk("valid", 8'h01, io_rdata_valid);
        chk("run", 8'h00, wdt_running);
        $display("test 1 end");
        host.wr(16'h0443, 8'h01);
        n = 0;
        repeat (20) @(negedge mclk) n += cpu_reset;
        chk("pulse", 8'h04, n[7:0]);
        chk("irq", 8'h00, wdt_irq);
        $display("test 2 end");
        @(negedge mclk) expire_irq_mode = 1;
        host.wr(16'h0443, 8'h02);
        repeat (15) @(negedge mclk);
        host.wr(16'h0443, 8'h02);
        repeat (15) @(negedge mclk);
        chk("run", 8'h01, wdt_running);
        repeat (10) @(negedge mclk);
        chk("irq", 8'h01, wdt_irq);
        host.rd(d);
        chk("irq", 8'h00, wdt_irq);
        $display("test 3 end");
        for (i = 0; i < 4; i++) begin
            host.wr(bad[i][23:8], bad[i][7:0]);
            chk("run", 8'h00, wdt_running);
        end
        $display("test 4 end");
        summarize;
    end
endmodule
